// ==== pls_chan_seq.sv ====
`timescale 1ns/1ps
module pls_chan_seq (
  // Clock and reset
  input  wire logic    clk_sys,
  input  wire logic    arst_n,
  // Millisecond enable
  input  wire logic    ms_tick,
  // Channel signals
  pls_seq_if.seq       ch
);

  // Negative times count as zero; long times saturate at 65535 ms
  function automatic logic [15:0] l11_to_ms(input logic [15:0] w);
    logic [4:0]  e;
    logic [4:0]  mag;
    logic [31:0] v;
    e   = w[pls_pkg::L11_EXP_MSB:pls_pkg::L11_EXP_LSB];
    mag = 5'(~e + 5'h01);
    v   = {21'h000000, w[pls_pkg::L11_MAN_MSB:0]};
    if (w[pls_pkg::L11_MAN_MSB]) begin
      v = 32'h00000000;
    end else if (e[4]) begin
      v = v >> mag;
    end else begin
      v = v << e[3:0];
    end
    return (|v[31:16]) ? 16'hFFFF : v[15:0];
  endfunction : l11_to_ms

  pls_pkg::pls_seq_state_t state;
  pls_pkg::pls_seq_state_t next_state;
  logic [15:0]             elapsed;
  logic [15:0]             watch_ms;
  logic                    watching;

  wire [15:0] delay_ms   = l11_to_ms(ch.delay_time);
  wire [15:0] rise_ms    = l11_to_ms(ch.rise_time);
  wire [15:0] timeout_ms = l11_to_ms(ch.timeout_time);
  wire        delay_done = (state == pls_pkg::PLS_DELAY) && (elapsed >= delay_ms);     // [R4]
  wire        rise_done  = (state == pls_pkg::PLS_RISE) && (elapsed >= rise_ms);       // [R5]
  wire        under_uv   = ch.vout_meas < ch.uv_limit;                                 // [R1] [R13]
  wire        good_set   = ch.vout_meas >= ch.good_assert;                             // [R2]
  wire        good_clr   = ch.release_uses_uv ? (ch.vout_meas <= ch.uv_limit)
                                              : (ch.vout_meas <= ch.good_release);     // [R3] [R1]
  wire        time_out   = watching && under_uv && (watch_ms >= timeout_ms);           // [R6]
  // Good is qualified by the next enable so it never outlives the enable pin
  wire        en_next    = (next_state == pls_pkg::PLS_RISE) || (next_state == pls_pkg::PLS_RUN);

  always_comb begin
    next_state = state;
    unique case (state)
      pls_pkg::PLS_OFF:   if (ch.on_req) next_state = pls_pkg::PLS_DELAY;
      pls_pkg::PLS_DELAY: if (!ch.on_req) next_state = pls_pkg::PLS_OFF;
                          else if (delay_done) next_state = pls_pkg::PLS_RISE;
      pls_pkg::PLS_RISE:  if (!ch.on_req) next_state = pls_pkg::PLS_OFF;
                          else if (rise_done) next_state = pls_pkg::PLS_RUN;
      pls_pkg::PLS_RUN:   if (!ch.on_req) next_state = pls_pkg::PLS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state   <= pls_pkg::PLS_OFF;
      elapsed <= 16'h0000;
    end else begin
      state   <= next_state;
      elapsed <= (next_state != state) ? 16'h0000 : (ms_tick ? elapsed + 16'h0001 : elapsed);
    end
  end

  // Outputs decode next_state, so they change on the same edge as the state, straight from flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch.out_en   <= 1'b0;
      ch.servo_go <= 1'b0;
      ch.good     <= 1'b0;
    end else begin
      ch.out_en   <= en_next;                                                             // [R4]
      ch.servo_go <= next_state == pls_pkg::PLS_RUN;                                       // [R5]
      if (!en_next) ch.good <= 1'b0;
      else if (good_set) ch.good <= 1'b1;                                                 // [R2]
      else if (good_clr) ch.good <= 1'b0;                                                 // [R3]
    end
  end

  // Start-up watch runs from enable until the output first clears the UV limit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      watching         <= 1'b0;
      watch_ms         <= 16'h0000;
      ch.startup_fault <= 1'b0;
    end else begin
      if (!ch.out_en) begin
        watching <= 1'b0;
        watch_ms <= 16'h0000;
      end else if (!watching && watch_ms == 16'h0000) begin
        watching <= 1'b1;
      end else if (watching && !under_uv) begin
        watching <= 1'b0;
        watch_ms <= 16'hFFFF;
      end else if (watching && ms_tick && watch_ms != 16'hFFFF) begin
        watch_ms <= watch_ms + 16'h0001;
      end
      // Sticky until the channel is turned off; a timeout wins over that clear
      if (time_out) ch.startup_fault <= 1'b1;                                             // [R6]
      else if (!ch.on_req) ch.startup_fault <= 1'b0;
    end
  end

endmodule : pls_chan_seq

// ==== pls_host_model.sv ====
`timescale 1ns/1ps
module pls_host_model (
  // Clock
  input wire logic        clk_sys,
  // Command port
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_page,
  output logic [15:0]     cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic        rsp_unmapped,
  input wire logic [15:0] rsp_rdata
);
  initial {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = '0;
  // Page goes with every command; data inverted once released
  task automatic xfer(input logic w, input logic [7:0] c, p, input logic [15:0] d,
                      output logic [15:0] q, output logic u);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_page  <= p;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;
    @(posedge clk_sys);
    q = rsp_rdata;
    u = rsp_unmapped;
  endtask : xfer
endmodule : pls_host_model

// ==== pls_limit_regs.sv ====
`timescale 1ns/1ps
// How it works
// R1 - Paged output UV limit, timeout and good-drop
// R2 - Good asserts at or above assert level
// R3 - Good releases at or below release level
// R4 - Enable pin follows on-request after delay
// R5 - Servo starts rise time after enable
// R6 - UV past startup timeout raises fault
// R7 - Eight-bit action bytes with listed defaults
// R8 - Paged overtemperature fault and warn limits
// R9 - Paged undertemperature warn and fault limits
// R10 - Unpaged input overvoltage limits versus sense pin
// R11 - Unpaged input undervoltage limits versus sense pin
// R12 - Paged overcurrent warn limit, volatile only
// R13 - Linear-16 voltages compare as unsigned mantissas
// R14 - Linear-11: 5-bit exponent, 11-bit mantissa
// R15 - Host selects page; input commands unpaged
module pls_limit_regs #(
  parameter int unsigned MS_CYCLES = pls_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_page,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic             rsp_unmapped,
  output logic [15:0]      rsp_rdata,
  // Configuration
  input  wire logic        good_release_uses_undervolt_sel,
  // Channel control and telemetry
  input  wire logic [1:0]  on_request,
  input  wire logic [15:0] vout_meas_0,
  input  wire logic [15:0] vout_meas_1,
  input  wire logic [15:0] iout_meas_0,
  input  wire logic [15:0] iout_meas_1,
  input  wire logic [15:0] temp_meas_0,
  input  wire logic [15:0] temp_meas_1,
  input  wire logic [15:0] input_sense_pin,
  // Channel outputs
  output logic [1:0]       channel_output_enable_pin,
  output logic [1:0]       supply_good,
  output logic [1:0]       servo_start,
  output logic [1:0]       startup_timeout_fault,
  output logic [1:0]       over_temp_fault,
  output logic [1:0]       over_temp_warn,
  output logic [1:0]       under_temp_warn,
  output logic [1:0]       under_temp_fault,
  output logic [1:0]       overcurrent_warn,
  // Input supply flags
  output logic             input_ov_fault,
  output logic             input_ov_warn,
  output logic             input_uv_warn,
  output logic             input_uv_fault
);

  localparam int unsigned NC = pls_pkg::NUM_CH;

  // Linear-11 to a signed fixed-point value scaled by 2^16, so mixed exponents compare directly
  function automatic logic signed [47:0] l11_fix(input logic [15:0] w);
    logic [4:0]         e;
    logic signed [47:0] m;
    e = w[pls_pkg::L11_EXP_MSB:pls_pkg::L11_EXP_LSB];
    m = 48'(signed'(w[pls_pkg::L11_MAN_MSB:0]));                          // [R14]
    return m <<< (5'(e + 5'h10));
  endfunction : l11_fix

  // Millisecond enable from a free divider
  logic [31:0] ms_div;
  logic        ms_tick;
  wire         ms_wrap = ms_div == 32'(MS_CYCLES - 1);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ms_div  <= 32'h00000000;
      ms_tick <= 1'b0;
    end else begin
      ms_div  <= ms_wrap ? 32'h00000000 : ms_div + 32'h00000001;
      ms_tick <= ms_wrap;
    end
  end

  // Command decode
  wire wr_req = cmd_valid && cmd_write;
  wire rd_req = cmd_valid && !cmd_write;
  wire rd_ch  = (cmd_page == 8'h01);                                      // [R15]

  // Paged storage
  logic [15:0] uv_limit     [NC];
  logic [7:0]  uv_action    [NC];
  logic [15:0] oc_warn      [NC];
  logic [15:0] ot_fault_lim [NC];
  logic [7:0]  ot_action    [NC];
  logic [15:0] ot_warn_lim  [NC];
  logic [15:0] ut_warn_lim  [NC];
  logic [15:0] ut_fault_lim [NC];
  logic [7:0]  ut_action    [NC];
  logic [15:0] good_on      [NC];
  logic [15:0] good_off     [NC];
  logic [15:0] ton_delay    [NC];
  logic [15:0] ton_rise     [NC];
  logic [15:0] ton_max      [NC];

  // Unpaged storage
  logic [15:0] in_ov_limit;
  logic [7:0]  in_ov_action;
  logic [15:0] in_ov_warn;
  logic [15:0] in_uv_warn;
  logic [15:0] in_uv_limit;
  logic [7:0]  in_uv_action;

  wire [15:0] vout_meas [NC];
  wire [15:0] iout_meas [NC];
  wire [15:0] temp_meas [NC];
  assign vout_meas[0] = vout_meas_0;
  assign vout_meas[1] = vout_meas_1;
  assign iout_meas[0] = iout_meas_0;
  assign iout_meas[1] = iout_meas_1;
  assign temp_meas[0] = temp_meas_0;
  assign temp_meas[1] = temp_meas_1;

  wire signed [47:0] vin_fix = l11_fix(input_sense_pin);

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_ch
      wire sel  = (cmd_page == 8'(g)) || (cmd_page == pls_pkg::PAGE_ALL);   // [R15]
      wire wr   = wr_req && sel;
      wire signed [47:0] t_fix = l11_fix(temp_meas[g]);

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          uv_limit[g]     <= pls_pkg::RST_OUT_UV_LIMIT;     // [R1]
          uv_action[g]    <= pls_pkg::RST_OUT_UV_ACTION;    // [R7]
          oc_warn[g]      <= pls_pkg::RST_OUT_OC_WARN;      // [R12]
          ot_fault_lim[g] <= pls_pkg::RST_OVER_TEMP_FAULT_LIMIT;   // [R8]
          ot_action[g]    <= pls_pkg::RST_OT_FAULT_ACTION;  // [R7]
          ot_warn_lim[g]  <= pls_pkg::RST_OVER_TEMP_WARN_LIMIT;    // [R8]
          ut_warn_lim[g]  <= pls_pkg::RST_UNDER_TEMP_WARN_LIMIT;    // [R9]
          ut_fault_lim[g] <= pls_pkg::RST_UNDER_TEMP_FAULT_LIMIT;   // [R9]
          ut_action[g]    <= pls_pkg::RST_UT_FAULT_ACTION;  // [R7]
          good_on[g]      <= pls_pkg::RST_GOOD_ASSERT;      // [R2]
          good_off[g]     <= pls_pkg::RST_GOOD_RELEASE;     // [R3]
          ton_delay[g]    <= pls_pkg::RST_TURN_ON_DELAY;    // [R4]
          ton_rise[g]     <= pls_pkg::RST_TURN_ON_RISE;     // [R5]
          ton_max[g]      <= pls_pkg::RST_STARTUP_TIMEOUT;  // [R6]
        end else if (wr) begin
          if (cmd_code == pls_pkg::CMD_OUT_UV_LIMIT)    uv_limit[g]     <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_OUT_UV_ACTION)   uv_action[g]    <= cmd_wdata[7:0];
          if (cmd_code == pls_pkg::CMD_OUT_OC_WARN)     oc_warn[g]      <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_OVER_TEMP_FAULT_LIMIT)  ot_fault_lim[g] <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_OT_FAULT_ACTION) ot_action[g]    <= cmd_wdata[7:0];
          if (cmd_code == pls_pkg::CMD_OVER_TEMP_WARN_LIMIT)   ot_warn_lim[g]  <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_UNDER_TEMP_WARN_LIMIT)   ut_warn_lim[g]  <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_UNDER_TEMP_FAULT_LIMIT)  ut_fault_lim[g] <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_UT_FAULT_ACTION) ut_action[g]    <= cmd_wdata[7:0];
          if (cmd_code == pls_pkg::CMD_GOOD_ASSERT)     good_on[g]      <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_GOOD_RELEASE)    good_off[g]     <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_TURN_ON_DELAY)   ton_delay[g]    <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_TURN_ON_RISE)    ton_rise[g]     <= cmd_wdata;
          if (cmd_code == pls_pkg::CMD_STARTUP_TIMEOUT) ton_max[g]      <= cmd_wdata;
        end
      end

      // Supervisor flags; the fault actions themselves are handled elsewhere
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          over_temp_fault[g]  <= 1'b0;
          over_temp_warn[g]   <= 1'b0;
          under_temp_warn[g]  <= 1'b0;
          under_temp_fault[g] <= 1'b0;
          overcurrent_warn[g] <= 1'b0;
        end else begin
          over_temp_fault[g]  <= t_fix > l11_fix(ot_fault_lim[g]);                  // [R8]
          over_temp_warn[g]   <= t_fix > l11_fix(ot_warn_lim[g]);                   // [R8]
          under_temp_warn[g]  <= t_fix < l11_fix(ut_warn_lim[g]);                   // [R9]
          under_temp_fault[g] <= t_fix < l11_fix(ut_fault_lim[g]);                  // [R9]
          overcurrent_warn[g] <= l11_fix(iout_meas[g]) > l11_fix(oc_warn[g]);        // [R12]
        end
      end

      pls_seq_if seq_bus ();
      assign seq_bus.on_req          = on_request[g];
      assign seq_bus.vout_meas       = vout_meas[g];
      assign seq_bus.uv_limit        = uv_limit[g];
      assign seq_bus.good_assert     = good_on[g];
      assign seq_bus.good_release    = good_off[g];
      assign seq_bus.release_uses_uv = good_release_uses_undervolt_sel;
      assign seq_bus.delay_time      = ton_delay[g];
      assign seq_bus.rise_time       = ton_rise[g];
      assign seq_bus.timeout_time    = ton_max[g];
      assign channel_output_enable_pin[g] = seq_bus.out_en;
      assign supply_good[g]               = seq_bus.good;
      assign servo_start[g]               = seq_bus.servo_go;
      assign startup_timeout_fault[g]     = seq_bus.startup_fault;

      pls_chan_seq u_seq (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ms_tick (ms_tick),
        .ch      (seq_bus)
      );
    end
  endgenerate

  // Input supply commands ignore the page
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      in_ov_limit  <= pls_pkg::RST_IN_OV_LIMIT;    // [R10]
      in_ov_action <= pls_pkg::RST_IN_OV_ACTION;   // [R7]
      in_ov_warn   <= pls_pkg::RST_IN_OV_WARN;     // [R10]
      in_uv_warn   <= pls_pkg::RST_IN_UV_WARN;     // [R11]
      in_uv_limit  <= pls_pkg::RST_IN_UV_LIMIT;    // [R11]
      in_uv_action <= pls_pkg::RST_IN_UV_ACTION;   // [R7]
    end else if (wr_req) begin
      if (cmd_code == pls_pkg::CMD_IN_OV_LIMIT)  in_ov_limit  <= cmd_wdata;
      if (cmd_code == pls_pkg::CMD_IN_OV_ACTION) in_ov_action <= cmd_wdata[7:0];
      if (cmd_code == pls_pkg::CMD_IN_OV_WARN)   in_ov_warn   <= cmd_wdata;
      if (cmd_code == pls_pkg::CMD_IN_UV_WARN)   in_uv_warn   <= cmd_wdata;
      if (cmd_code == pls_pkg::CMD_IN_UV_LIMIT)  in_uv_limit  <= cmd_wdata;
      if (cmd_code == pls_pkg::CMD_IN_UV_ACTION) in_uv_action <= cmd_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      input_ov_fault <= 1'b0;
      input_ov_warn  <= 1'b0;
      input_uv_warn  <= 1'b0;
      input_uv_fault <= 1'b0;
    end else begin
      input_ov_fault <= vin_fix > l11_fix(in_ov_limit);   // [R10]
      input_ov_warn  <= vin_fix > l11_fix(in_ov_warn);    // [R10]
      input_uv_warn  <= vin_fix < l11_fix(in_uv_warn);    // [R11]
      input_uv_fault <= vin_fix < l11_fix(in_uv_limit);   // [R11]
    end
  end

  // Read selection; page 0xFF and page 0 read channel 0
  wire [15:0] rd_word =
    (cmd_code == pls_pkg::CMD_OUT_FORMAT)      ? {8'h00, pls_pkg::RST_OUT_FORMAT} :   // [R13]
    (cmd_code == pls_pkg::CMD_OUT_UV_LIMIT)    ? uv_limit[rd_ch] :
    (cmd_code == pls_pkg::CMD_OUT_UV_ACTION)   ? {8'h00, uv_action[rd_ch]} :
    (cmd_code == pls_pkg::CMD_OUT_OC_WARN)     ? oc_warn[rd_ch] :
    (cmd_code == pls_pkg::CMD_OVER_TEMP_FAULT_LIMIT)  ? ot_fault_lim[rd_ch] :
    (cmd_code == pls_pkg::CMD_OT_FAULT_ACTION) ? {8'h00, ot_action[rd_ch]} :
    (cmd_code == pls_pkg::CMD_OVER_TEMP_WARN_LIMIT)   ? ot_warn_lim[rd_ch] :
    (cmd_code == pls_pkg::CMD_UNDER_TEMP_WARN_LIMIT)   ? ut_warn_lim[rd_ch] :
    (cmd_code == pls_pkg::CMD_UNDER_TEMP_FAULT_LIMIT)  ? ut_fault_lim[rd_ch] :
    (cmd_code == pls_pkg::CMD_UT_FAULT_ACTION) ? {8'h00, ut_action[rd_ch]} :
    (cmd_code == pls_pkg::CMD_IN_OV_LIMIT)     ? in_ov_limit :
    (cmd_code == pls_pkg::CMD_IN_OV_ACTION)    ? {8'h00, in_ov_action} :
    (cmd_code == pls_pkg::CMD_IN_OV_WARN)      ? in_ov_warn :
    (cmd_code == pls_pkg::CMD_IN_UV_WARN)      ? in_uv_warn :
    (cmd_code == pls_pkg::CMD_IN_UV_LIMIT)     ? in_uv_limit :
    (cmd_code == pls_pkg::CMD_IN_UV_ACTION)    ? {8'h00, in_uv_action} :
    (cmd_code == pls_pkg::CMD_GOOD_ASSERT)     ? good_on[rd_ch] :
    (cmd_code == pls_pkg::CMD_GOOD_RELEASE)    ? good_off[rd_ch] :
    (cmd_code == pls_pkg::CMD_TURN_ON_DELAY)   ? ton_delay[rd_ch] :
    (cmd_code == pls_pkg::CMD_TURN_ON_RISE)    ? ton_rise[rd_ch] :
    (cmd_code == pls_pkg::CMD_STARTUP_TIMEOUT) ? ton_max[rd_ch] : 16'h0000;

  wire rd_hit = (cmd_code == pls_pkg::CMD_OUT_FORMAT) ||
                ((cmd_code >= pls_pkg::CMD_OUT_UV_LIMIT) && (cmd_code <= pls_pkg::CMD_OUT_UV_ACTION)) ||
                (cmd_code == pls_pkg::CMD_OUT_OC_WARN) ||
                ((cmd_code >= pls_pkg::CMD_OVER_TEMP_FAULT_LIMIT) && (cmd_code <= pls_pkg::CMD_IN_UV_ACTION)) ||
                ((cmd_code >= pls_pkg::CMD_GOOD_ASSERT) && (cmd_code <= pls_pkg::CMD_STARTUP_TIMEOUT));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid    <= 1'b0;
      rsp_unmapped <= 1'b0;
      rsp_rdata    <= 16'h0000;
    end else begin
      rsp_valid    <= cmd_valid;
      rsp_unmapped <= cmd_valid && !rd_hit;
      rsp_rdata    <= rd_req ? rd_word : 16'h0000;
    end
  end

endmodule : pls_limit_regs

// ==== pls_limit_regs_properties.sv ====
`timescale 1ns/1ps
module pls_limit_regs_properties (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Command port
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic        rsp_valid,
  input wire logic        rsp_unmapped,
  input wire logic [15:0] rsp_rdata,
  // Channel
  input wire logic [1:0]  on_request,
  input wire logic [1:0]  channel_output_enable_pin,
  input wire logic [1:0]  supply_good,
  input wire logic [1:0]  servo_start
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  rsp_follows_a: assert property (cmd_valid |=> rsp_valid) else $error("missing response");
  rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid)) else $error("stray response");
  unmapped_zero_a: assert property (rsp_unmapped |-> rsp_valid && rsp_rdata == 16'h0000)
    else $error("bad unmapped answer");
  write_zero_a: assert property (rsp_valid && $past(cmd_write) |-> rsp_rdata == 16'h0000)
    else $error("write returned data");
  good_needs_en_a: assert property (supply_good[0] |-> channel_output_enable_pin[0])
    else $error("good without enable");
  servo_needs_en_a: assert property (servo_start[0] |-> channel_output_enable_pin[0])
    else $error("servo without enable");
  en_off_a: assert property ($fell(on_request[0]) |-> ##2 !channel_output_enable_pin[0])
    else $error("enable held after off");
  en_cause_a: assert property ($rose(channel_output_enable_pin[0]) |-> $past(on_request[0]))
    else $error("enable without request");
  cover property (cmd_valid && cmd_write);
  cover property (rsp_unmapped);
  cover property ($rose(servo_start[0]));
endmodule : pls_limit_regs_properties
bind pls_limit_regs pls_limit_regs_properties u_props (.*);

// ==== pls_limit_regs_tb_top.sv ====
`timescale 1ns/1ps
module pls_limit_regs_tb_top;
  logic clk_sys, arst_n, cmd_valid, cmd_write, rsp_valid, rsp_unmapped, good_release_uses_undervolt_sel, u;
  logic input_ov_fault, input_ov_warn, input_uv_warn, input_uv_fault;
  logic [7:0] cmd_code, cmd_page;
  logic [15:0] cmd_wdata, rsp_rdata, vout_meas_0, vout_meas_1, iout_meas_0, iout_meas_1, q;
  logic [15:0] temp_meas_0, temp_meas_1, input_sense_pin;
  logic [1:0] on_request, channel_output_enable_pin, supply_good, servo_start, startup_timeout_fault;
  logic [1:0] over_temp_fault, over_temp_warn, under_temp_warn, under_temp_fault, overcurrent_warn;
  int err_total, checks, n;
  wire [2:0] seq_mon = {startup_timeout_fault[0], servo_start[0], channel_output_enable_pin[0]};
  pls_limit_regs #(.MS_CYCLES(10)) DUT (.*);
  pls_host_model u_host (.*);
  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic t_defaults;
    logic [7:0] cd [20] = '{8'h44, 8'h45, 8'h4A, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
                            8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5E, 8'h5F, 8'h60, 8'h61, 8'h62};
    logic [15:0] dv [20] = '{16'h1CCD, 16'h7F, 16'hCA80, 16'hEA08, 16'hB8, 16'hE3C0, 16'h8000,
                             16'hCD80, 16'hB8, 16'hD3C0, 16'h80, 16'hD380, 16'h8000, 16'h8000,
                             16'h0, 16'h1EB8, 16'h1E14, 16'hBA00, 16'hD280, 16'hD3C0};
    for (int i = 0; i < 20; i++) begin
      u_host.xfer(1'b0, cd[i], 8'h01, 16'h0, q, u);
      chk(q, dv[i]);
    end
  endtask : t_defaults
  task automatic t_paging;
    u_host.xfer(1'b1, 8'h44, 8'h01, 16'h1234, q, u);
    u_host.xfer(1'b0, 8'h44, 8'h00, 16'h0, q, u);
    chk(q, 16'h1CCD);
    u_host.xfer(1'b0, 8'h44, 8'h01, 16'h0, q, u);
    chk(q, 16'h1234);
    u_host.xfer(1'b1, 8'h57, 8'h01, 16'hD3A0, q, u);
    u_host.xfer(1'b0, 8'h57, 8'h00, 16'h0, q, u);
    chk(q, 16'hD3A0);
    u_host.xfer(1'b1, 8'h45, 8'hFF, 16'hAB5A, q, u);
    u_host.xfer(1'b0, 8'h45, 8'h01, 16'h0, q, u);
    chk(q, 16'h005A);
    u_host.xfer(1'b0, 8'h30, 8'h00, 16'h0, q, u);
    chk({q[15:1], u}, 16'h0001);
    u_host.xfer(1'b0, 8'h20, 8'h00, 16'h0, q, u);
    chk(q, 16'h0013);
  endtask : t_paging
  task automatic wait_on(input int k, input int lim);
    n = 0;
    while (seq_mon[k] !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_on
  task automatic good_at(input logic [15:0] v, input logic g);
    vout_meas_0 <= v;
    repeat (3) @(posedge clk_sys);
    chk({15'h0, supply_good[0]}, {15'h0, g});
  endtask : good_at
  task automatic t_seq;
    on_request[0] <= 1'b1;
    wait_on(0, 100);
    chk(16'(channel_output_enable_pin[0] && n <= 32), 16'h1);
    wait_on(1, 200);
    chk(16'(servo_start[0] && n >= 80 && n <= 115), 16'h1);
    wait_on(2, 100);
    chk(16'(startup_timeout_fault[0] && n >= 20), 16'h1);
    good_at(16'h1EB7, 1'b0);
    good_at(16'h1EB8, 1'b1);
    good_at(16'h1E15, 1'b1);
    good_at(16'h1E14, 1'b0);
    good_release_uses_undervolt_sel <= 1'b1;
    good_at(16'h1EB8, 1'b1);
    good_at(16'h1E00, 1'b1);
    good_at(16'h1CCD, 1'b0);
    on_request[0] <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({14'h0, channel_output_enable_pin[0], startup_timeout_fault[0]}, 16'h0);
  endtask : t_seq
  task automatic t_limits;
    temp_meas_0 <= 16'hF208;
    iout_meas_0 <= 16'hD280;
    input_sense_pin <= 16'hDBC0;
    repeat (3) @(posedge clk_sys);
    chk({12'h0, over_temp_fault[0], over_temp_warn[0], input_ov_fault, input_ov_warn}, 16'hF);
    chk({15'h0, overcurrent_warn[0]}, 16'h1);
    temp_meas_0 <= 16'h07F6;
    input_sense_pin <= 16'h07FF;
    repeat (3) @(posedge clk_sys);
    chk({12'h0, under_temp_fault[0], under_temp_warn[0], input_uv_fault, input_uv_warn}, 16'hF);
  endtask : t_limits
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    arst_n = 1'b0;
    {on_request, good_release_uses_undervolt_sel} = '0;
    {vout_meas_0, vout_meas_1, iout_meas_0, iout_meas_1, temp_meas_0, temp_meas_1, input_sense_pin} = '0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_defaults();
    t_paging();
    t_seq();
    t_limits();
    test_done();
  end
endmodule : pls_limit_regs_tb_top

// ==== pls_pkg.sv ====
package pls_pkg;

  localparam int unsigned NUM_CH = 2;

  // Command codes of this slice
  localparam logic [7:0] CMD_OUT_FORMAT       = 8'h20;
  localparam logic [7:0] CMD_OUT_UV_LIMIT     = 8'h44;
  localparam logic [7:0] CMD_OUT_UV_ACTION    = 8'h45;
  localparam logic [7:0] CMD_OUT_OC_WARN      = 8'h4A;
  localparam logic [7:0] CMD_OVER_TEMP_FAULT_LIMIT   = 8'h4F;
  localparam logic [7:0] CMD_OT_FAULT_ACTION  = 8'h50;
  localparam logic [7:0] CMD_OVER_TEMP_WARN_LIMIT    = 8'h51;
  localparam logic [7:0] CMD_UNDER_TEMP_WARN_LIMIT    = 8'h52;
  localparam logic [7:0] CMD_UNDER_TEMP_FAULT_LIMIT   = 8'h53;
  localparam logic [7:0] CMD_UT_FAULT_ACTION  = 8'h54;
  localparam logic [7:0] CMD_IN_OV_LIMIT      = 8'h55;
  localparam logic [7:0] CMD_IN_OV_ACTION     = 8'h56;
  localparam logic [7:0] CMD_IN_OV_WARN       = 8'h57;
  localparam logic [7:0] CMD_IN_UV_WARN       = 8'h58;
  localparam logic [7:0] CMD_IN_UV_LIMIT      = 8'h59;
  localparam logic [7:0] CMD_IN_UV_ACTION     = 8'h5A;
  localparam logic [7:0] CMD_GOOD_ASSERT      = 8'h5E;
  localparam logic [7:0] CMD_GOOD_RELEASE     = 8'h5F;
  localparam logic [7:0] CMD_TURN_ON_DELAY    = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RISE     = 8'h61;
  localparam logic [7:0] CMD_STARTUP_TIMEOUT  = 8'h62;

  // Page value that addresses every channel
  localparam logic [7:0] PAGE_ALL = 8'hFF;

  // Reset values
  localparam logic [7:0]  RST_OUT_FORMAT      = 8'h13;
  localparam logic [15:0] RST_OUT_UV_LIMIT    = 16'h1CCD;
  localparam logic [7:0]  RST_OUT_UV_ACTION   = 8'h7F;
  localparam logic [15:0] RST_OUT_OC_WARN     = 16'hCA80;
  localparam logic [15:0] RST_OVER_TEMP_FAULT_LIMIT  = 16'hEA08;
  localparam logic [7:0]  RST_OT_FAULT_ACTION = 8'hB8;
  localparam logic [15:0] RST_OVER_TEMP_WARN_LIMIT   = 16'hE3C0;
  localparam logic [15:0] RST_UNDER_TEMP_WARN_LIMIT   = 16'h8000;
  localparam logic [15:0] RST_UNDER_TEMP_FAULT_LIMIT  = 16'hCD80;
  localparam logic [7:0]  RST_UT_FAULT_ACTION = 8'hB8;
  localparam logic [15:0] RST_IN_OV_LIMIT     = 16'hD3C0;
  localparam logic [7:0]  RST_IN_OV_ACTION    = 8'h80;
  localparam logic [15:0] RST_IN_OV_WARN      = 16'hD380;
  localparam logic [15:0] RST_IN_UV_WARN      = 16'h8000;
  localparam logic [15:0] RST_IN_UV_LIMIT     = 16'h8000;
  localparam logic [7:0]  RST_IN_UV_ACTION    = 8'h00;
  localparam logic [15:0] RST_GOOD_ASSERT     = 16'h1EB8;
  localparam logic [15:0] RST_GOOD_RELEASE    = 16'h1E14;
  localparam logic [15:0] RST_TURN_ON_DELAY   = 16'hBA00;
  localparam logic [15:0] RST_TURN_ON_RISE    = 16'hD280;
  localparam logic [15:0] RST_STARTUP_TIMEOUT = 16'hD3C0;

  // Linear-11 field layout
  localparam int unsigned L11_EXP_MSB = 15;
  localparam int unsigned L11_EXP_LSB = 11;
  localparam int unsigned L11_MAN_MSB = 10;

  // Millisecond time base
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_IN_NS      = 1000000;
  localparam int unsigned CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PLS_OFF,
    PLS_DELAY,
    PLS_RISE,
    PLS_RUN
  } pls_seq_state_t;

endpackage : pls_pkg

// ==== pls_seq_if.sv ====
`timescale 1ns/1ps
interface pls_seq_if;
  logic        on_req;
  logic [15:0] vout_meas;
  logic [15:0] uv_limit;
  logic [15:0] good_assert;
  logic [15:0] good_release;
  logic        release_uses_uv;
  logic [15:0] delay_time;
  logic [15:0] rise_time;
  logic [15:0] timeout_time;
  logic        out_en;
  logic        good;
  logic        servo_go;
  logic        startup_fault;

  modport regs (output on_req, vout_meas, uv_limit, good_assert, good_release, release_uses_uv,
                output delay_time, rise_time, timeout_time,
                input  out_en, good, servo_go, startup_fault);
  modport seq  (input  on_req, vout_meas, uv_limit, good_assert, good_release, release_uses_uv,
                input  delay_time, rise_time, timeout_time,
                output out_en, good, servo_go, startup_fault);
endinterface : pls_seq_if
